/* File: testbench/jptb_assertions.sv */
// port checker for the translation buffer
`timescale 1ns/1ns
module jptb_checker (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [4:0] reg_num_in,
  input wire logic [63:0] reg_rdata_out,
  input wire logic lk_valid_in,
  input wire logic lk_store_in,
  input wire logic lk_done_out,
  input wire logic [2:0] lk_coherency_out,
  input wire logic lk_writable_out,
  input wire logic lk_page_valid_out,
  input wire logic lk_bypass_cache_out,
  input wire logic lk_cacheable_out,
  input wire logic lk_coh_reserved_out,
  input wire logic lk_miss_out,
  input wire logic load_translation_fault_out,
  input wire logic store_translation_fault_out,
  input wire logic lk_modify_fault_out,
  input wire logic lk_refill_vector_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // -------
  // lookup
  // -------
  lookup_done_a: assert property (
    lk_valid_in |=> lk_done_out) else $error("no lookup answer");
  refill_vector_a: assert property (
    lk_refill_vector_out == lk_miss_out) else $error("refill select");
  miss_typed_a: assert property (
    lk_miss_out |-> lk_done_out && !lk_page_valid_out &&
    store_translation_fault_out == $past(lk_store_in) &&
    load_translation_fault_out != $past(lk_store_in)) else $error("miss");
  invalid_fault_a: assert property (
    lk_done_out && !lk_miss_out |-> store_translation_fault_out ==
    ($past(lk_store_in) && !lk_page_valid_out) &&
    load_translation_fault_out ==
    (!$past(lk_store_in) && !lk_page_valid_out)) else $error("invalid");
  modify_fault_a: assert property (
    lk_done_out && !lk_miss_out |-> lk_modify_fault_out ==
    ($past(lk_store_in) && lk_page_valid_out && !lk_writable_out))
    else $error("modify fault");
  coh_decode_a: assert property (
    lk_bypass_cache_out == (lk_coherency_out == 3'h2) &&
    lk_cacheable_out == (lk_coherency_out == 3'h3) &&
    lk_coh_reserved_out != (lk_coherency_out inside {3'h2, 3'h3, 3'h7}))
    else $error("coherency decode");
  // -------
  // staging
  // -------
  hi_reserved_a: assert property (
    $past(reg_num_in) == 5'h0a |->
    reg_rdata_out[61:40] == 22'h0 && reg_rdata_out[12:8] == 5'h0)
    else $error("high reserved bits");
  lo_reserved_a: assert property (
    $past(reg_num_in) inside {5'h02, 5'h03} |->
    reg_rdata_out[63:30] == 34'h0) else $error("low reserved bits");
  cover property (lk_miss_out);
  cover property (lk_modify_fault_out);
  cover property (lk_done_out && lk_page_valid_out && lk_bypass_cache_out);
endmodule
bind jptb_top jptb_checker chk (.clk_in, .rst_b_in, .reg_num_in,
  .reg_rdata_out, .lk_valid_in, .lk_store_in, .lk_done_out,
  .lk_coherency_out, .lk_writable_out, .lk_page_valid_out,
  .lk_bypass_cache_out, .lk_cacheable_out, .lk_coh_reserved_out,
  .lk_miss_out, .load_translation_fault_out, .store_translation_fault_out,
  .lk_modify_fault_out, .lk_refill_vector_out);

/* File: testbench/jptb_core_model.sv */
// core-side model issuing one lookup per request
`timescale 1ns/1ns
module jptb_core_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic store_in,
  input wire logic [63:0] vaddr_in,
  input wire logic [1:0] gap_in,
  output logic lk_valid_out,
  output logic lk_store_out,
  output logic [63:0] lk_vaddr_out
);
  initial begin
    lk_valid_out = 1'b0;
    lk_store_out = 1'b0;
    lk_vaddr_out = 64'h0;
  end
  // idle lines show the inverse, so a stale address is never reused
  always begin
    @(posedge clk_in);
    if (go_in) begin
      repeat (gap_in) @(posedge clk_in);
      lk_valid_out <= 1'b1;
      lk_store_out <= store_in;
      lk_vaddr_out <= vaddr_in;
      @(posedge clk_in);
      lk_valid_out <= 1'b0;
      lk_store_out <= ~store_in;
      lk_vaddr_out <= ~vaddr_in;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the translation buffer
`timescale 1ns/1ns
`include "jptb_params.svh"
module tb_top;
  import jptb_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic reg_wr_en_in = 1'b0;
  logic op_valid_in = 1'b0;
  logic go = 1'b0;
  logic st = 1'b0;
  logic [1:0] gap = 2'h0;
  logic [4:0] reg_num_in = 5'h0;
  logic [63:0] reg_wdata_in = 64'h0;
  logic [63:0] va = 64'h0;
  jptb_op_t op_code_in = JPTB_OP_PROBE;
  logic lk_valid_in, lk_store_in, lk_done_out, lk_writable_out;
  logic lk_page_valid_out, lk_miss_out, lk_bypass_cache_out;
  logic lk_cacheable_out, lk_coh_reserved_out, lk_refill_vector_out;
  logic load_translation_fault_out, store_translation_fault_out;
  logic lk_modify_fault_out;
  logic [63:0] lk_vaddr_in, reg_rdata_out, got, a64;
  logic [23:0] lk_frame_number_out;
  logic [2:0] lk_coherency_out;
  logic [63:0] e_hi [64], e_l0 [64], e_l1 [64], e_mk [64];
  logic [63:0] idx_m;
  logic [7:0] asid_m;
  logic [36:0] ev, gv;
  logic [4:0] rn [6] = '{`JPTB_REG_ENTRY_HIGH, `JPTB_REG_LO_EVEN,
    `JPTB_REG_PAGE_MASK, `JPTB_REG_INDEX, `JPTB_REG_WIRED, 5'h04};
  logic [63:0] rx [6] = '{64'hc00000ffffffe0ff, 64'h3fffffff,
    64'h1ffe000, 64'h3f, 64'h3f, 64'h0};
  // software keeps reserved zero fields at zero; fill bits are written as ones but read zero
  logic [63:0] wx [6] = '{64'hffffffffffffe0ff, 64'h3fffffff,
    64'h1ffe000, 64'h3f, 64'h3f, '1};
  int n_errors = 0, tests_run = 0, cyc = 0, f, j;
  jptb_top #(.ENTRIES(64)) dut (.clk_in, .rst_b_in, .reg_wr_en_in,
    .reg_num_in, .reg_wdata_in, .reg_rdata_out, .op_valid_in, .op_code_in,
    .lk_valid_in, .lk_store_in, .lk_vaddr_in, .lk_done_out,
    .lk_frame_number_out, .lk_coherency_out, .lk_writable_out,
    .lk_page_valid_out, .lk_bypass_cache_out, .lk_cacheable_out,
    .lk_coh_reserved_out, .lk_miss_out, .load_translation_fault_out,
    .store_translation_fault_out, .lk_modify_fault_out,
    .lk_refill_vector_out);
  jptb_core_model core (.clk_in, .go_in(go), .store_in(st), .vaddr_in(va),
    .gap_in(gap), .lk_valid_out(lk_valid_in), .lk_store_out(lk_store_in),
    .lk_vaddr_out(lk_vaddr_in));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_lk(input logic [37:0] g, input logic [37:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] n, input logic [63:0] d);
    @(posedge clk_in);
    reg_wr_en_in <= 1'b1;
    reg_num_in <= n;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] n);
    @(posedge clk_in);
    reg_num_in <= n;
    repeat (2) @(posedge clk_in);
    #1 got = reg_rdata_out;
  endtask
  task automatic op(input jptb_op_t c);
    @(posedge clk_in);
    op_valid_in <= 1'b1;
    op_code_in <= c;
    @(posedge clk_in);
    op_valid_in <= 1'b0;
  endtask
  task automatic fill(input int i, input logic [63:0] h, l0, l1, m,
    input jptb_op_t c);
    asid_m = h[7:0];
    idx_m = 64'(i);
    if (c == JPTB_OP_WRITE_INDEX) begin
      e_hi[i] = h;
      e_l0[i] = l0;
      e_l1[i] = l1;
      e_mk[i] = m;
    end
    wr(`JPTB_REG_ENTRY_HIGH, h);
    wr(`JPTB_REG_LO_EVEN, l0);
    wr(`JPTB_REG_LO_ODD, l1);
    wr(`JPTB_REG_PAGE_MASK, m);
    wr(`JPTB_REG_INDEX, 64'(i));
    op(c);
  endtask
  // lowest matching entry wins, as the buffer resolves duplicates
  function automatic int find(input logic [63:0] a);
    for (int i = 0; i < 64; i++) begin
      if ((((a[39:13] ^ e_hi[i][39:13]) & ~{15'h0, e_mk[i][24:13]}) == 0)
        && ((e_l0[i][0] & e_l1[i][0]) || e_hi[i][7:0] == asid_m)) begin
        return i;
      end
    end
    return -1;
  endfunction
  function automatic logic [36:0] lk_exp(input logic s, input logic [63:0] a);
    int i;
    logic [63:0] lo;
    i = find(a);
    if (i < 0) begin
      return {30'h0, 2'h3, !s, s, 3'h0};
    end
    lo = a[12 + $countones(e_mk[i][24:13])] ? e_l1[i] : e_l0[i];
    return {lo[29:3], lo[5:3] == 3'h2, lo[5:3] == 3'h3,
      !(lo[5:3] inside {3'h2, 3'h3, 3'h7}), 2'h0, !lo[1] && !s,
      !lo[1] && s, s && lo[1] && !lo[2], lo[1], lo[2]};
  endfunction
  task automatic look(input logic s, input logic [63:0] a);
    @(posedge clk_in);
    go <= 1'b1;
    st <= s;
    va <= a;
    gap <= 2'($urandom);
    @(posedge clk_in);
    go <= 1'b0;
    for (int k = 0; k < 8 && lk_done_out !== 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    ev = lk_exp(s, a);
    gv = {lk_frame_number_out, lk_coherency_out, lk_bypass_cache_out,
      lk_cacheable_out, lk_coh_reserved_out, lk_miss_out,
      lk_refill_vector_out, load_translation_fault_out,
      store_translation_fault_out, lk_modify_fault_out, lk_page_valid_out,
      lk_writable_out};
    if (ev[6]) gv[36:7] = 30'h0;
    cmp_lk({lk_done_out, gv}, {1'b1, ev});
  endtask
  initial begin
    void'($urandom(38373));
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (int k = 0; k < 6; k++) begin
      rd(rn[k]);
      cmp(got, 64'h0);
      wr(rn[k], wx[k]);
      rd(rn[k]);
      cmp(got, rx[k]);
    end
    // wired at the top pins the random index there
    wr(`JPTB_REG_RANDOM, 64'h0);
    rd(`JPTB_REG_RANDOM);
    cmp(got, 64'h3f);
    wr(`JPTB_REG_WIRED, 64'h0);
    $display("test registers done");
    for (int i = 0; i < 64; i++) begin
      fill(i, {1'b0, 1'($urandom), 22'h0, 27'($urandom), 5'h0, 8'($urandom)},
        {34'h0, 24'($urandom), 3'(i), 3'($urandom)},
        {34'h0, 24'($urandom), 3'(i + 1), 3'($urandom)},
        {39'h0, 12'((1 << (2 * ($urandom % 7))) - 1), 13'h0},
        JPTB_OP_WRITE_INDEX);
    end
    for (int t = 0; t < 8; t++) begin
      j = t == 0 ? 0 : t == 1 ? 63 : $urandom % 64;
      wr(`JPTB_REG_INDEX, 64'(j));
      op(JPTB_OP_READ);
      idx_m = 64'(j);
      asid_m = e_hi[j][7:0];
      rd(`JPTB_REG_ENTRY_HIGH);
      cmp(got, e_hi[j]);
      rd(`JPTB_REG_LO_EVEN);
      cmp(got, {e_l0[j][63:1], e_l0[j][0] & e_l1[j][0]});
      rd(`JPTB_REG_LO_ODD);
      cmp(got, {e_l1[j][63:1], e_l0[j][0] & e_l1[j][0]});
      rd(`JPTB_REG_PAGE_MASK);
      cmp(got, e_mk[j]);
    end
    $display("test entry read done");
    for (int t = 0; t < 48; t++) begin
      j = t < 8 ? t : $urandom % 64;
      got = {e_hi[j][63:8], $urandom % 4 ? e_hi[j][7:0] : 8'($urandom)};
      asid_m = got[7:0];
      wr(`JPTB_REG_ENTRY_HIGH, got);
      a64 = {24'h0, e_hi[j][39:13], 13'h0} ^
        (64'($urandom) & (e_mk[j] | 64'h1fff));
      if (t % 5 == 4) a64 = {24'h0, 8'($urandom), 32'($urandom)};
      look(1'($urandom), a64);
    end
    $display("test lookups done");
    for (int t = 0; t < 8; t++) begin
      j = $urandom % 64;
      got = t % 2 ? {24'h0, 27'($urandom), 5'h0, 8'($urandom)} : e_hi[j];
      asid_m = got[7:0];
      wr(`JPTB_REG_ENTRY_HIGH, got);
      f = find({24'h0, got[39:13], 13'h0});
      idx_m = f < 0 ? idx_m | 64'h80000000 : 64'(f);
      op(JPTB_OP_PROBE);
      rd(`JPTB_REG_INDEX);
      cmp(got, idx_m);
    end
    $display("test probes done");
    wr(`JPTB_REG_WIRED, 64'h30);
    rd(`JPTB_REG_RANDOM);
    cmp(64'(got <= 64'h3f && got >= 64'h30), 64'h1);
    fill(0, {24'h0, 27'h7ffffff, 13'h0}, 64'h1f, 64'h1f, 64'h0,
      JPTB_OP_WRITE_RANDOM);
    op(JPTB_OP_PROBE);
    rd(`JPTB_REG_INDEX);
    cmp(64'({got[31], got[5:0] >= 6'h30}), 64'h1);
    $display("test random write done");
    complete_run();
  end
endmodule

/* File: verilog/jptb_params.svh */
// offsets, field positions and reset values of the translation buffer
`ifndef JPTB_PARAMS_SVH
`define JPTB_PARAMS_SVH

// ----------------------------------------------------------------
// register numbers on the control-unit register port
// ----------------------------------------------------------------
`define JPTB_REG_INDEX 5'h00
`define JPTB_REG_RANDOM 5'h01
`define JPTB_REG_LO_EVEN 5'h02
`define JPTB_REG_LO_ODD 5'h03
`define JPTB_REG_PAGE_MASK 5'h05
`define JPTB_REG_WIRED 5'h06
`define JPTB_REG_ENTRY_HIGH 5'h0a

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define JPTB_HI_REGION_HI 63
`define JPTB_HI_REGION_LO 62
`define JPTB_HI_PAIRED_PAGE_NUMBER_HI 39
`define JPTB_HI_PAIRED_PAGE_NUMBER_LO 13
`define JPTB_HI_ASID_HI 7
`define JPTB_HI_ASID_LO 0
`define JPTB_MASK_HI 24
`define JPTB_MASK_LO 13
`define JPTB_LO_PFN_HI 29
`define JPTB_LO_PFN_LO 6
`define JPTB_LO_COH_HI 5
`define JPTB_LO_COH_LO 3
`define JPTB_LO_DIRTY 2
`define JPTB_LO_VALID 1
`define JPTB_LO_GLOBAL 0
`define JPTB_INDEX_FAIL 31
`define JPTB_PAGE_LSB 12

// ----------------------------------------------------------------
// coherency codes and reset values
// ----------------------------------------------------------------
`define JPTB_COH_UNCACHED 3'h2
`define JPTB_COH_WRITEBACK 3'h3
`define JPTB_COH_UNC_ACCEL 3'h7
`define JPTB_WIRED_RESET 6'h00

`endif

/* File: verilog/jptb_pkg.sv */
// types shared by the translation buffer
package jptb_pkg;

  // ----------------------------------------------------------------
  // maintenance operations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    JPTB_OP_PROBE = 2'h0,
    JPTB_OP_READ = 2'h1,
    JPTB_OP_WRITE_INDEX = 2'h2,
    JPTB_OP_WRITE_RANDOM = 2'h3
  } jptb_op_t;

endpackage

/* File: verilog/jptb_top.sv */
// paired-page translation buffer with its staging registers
`timescale 1ns/1ns
`include "jptb_params.svh"

// Overview of operation
// - every entry keeps an 8-bit address-space identifier
// - every entry keeps the page number halved, covering an even/odd pair
// - global bit lives in entries, reads as reserved in high register
// - reserved zero fields read zero; software writes zeros there
// - region fill reads zero, ignores writes; region 00 user, 01 supervisor
// - set writable bit permits stores; clear bit raises modification fault
// - clear valid bit raises load or store invalid fault
// - global set in both low registers makes entry ignore identifier
// - coherency 2 uncached, 3 write-back, 7 accelerated, others reserved
// - coherency 010 goes straight to main memory, bypassing caches
// - compare masked upper address bits, and identifier unless global
// - on match output frame, coherency, writable and valid of half
// - valid bit never decides a match, only checked afterwards
// - no matching entry raises a buffer miss
// - probe, read, indexed write and random write are supported
// - miss is dispatched through its own refill vector
// - sixty-four entries, each reachable by index
module jptb_top
  import jptb_pkg::*;
#(
  parameter int ENTRIES = 64
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic reg_wr_en_in,
  input wire logic [4:0] reg_num_in,
  input wire logic [63:0] reg_wdata_in,
  output logic [63:0] reg_rdata_out,
  input wire logic op_valid_in,
  input wire jptb_op_t op_code_in,
  input wire logic lk_valid_in,
  input wire logic lk_store_in,
  input wire logic [63:0] lk_vaddr_in,
  output logic lk_done_out,
  output logic [23:0] lk_frame_number_out,
  output logic [2:0] lk_coherency_out,
  output logic lk_writable_out,
  output logic lk_page_valid_out,
  output logic lk_bypass_cache_out,
  output logic lk_cacheable_out,
  output logic lk_coh_reserved_out,
  output logic lk_miss_out,
  output logic load_translation_fault_out,
  output logic store_translation_fault_out,
  output logic lk_modify_fault_out,
  output logic lk_refill_vector_out
);

  localparam int IW = $clog2(ENTRIES);
  localparam logic [IW-1:0] TOP_INDEX = IW'(ENTRIES - 1);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q, rst_n;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end
  // ----------------------------------------------------------------
  // entry storage
  // ----------------------------------------------------------------
  // identifier per entry
  logic [7:0] ent_asid [ENTRIES];
  logic [26:0] ent_paired_page_number [ENTRIES];
  logic [11:0] ent_mask [ENTRIES];
  logic [1:0] ent_region [ENTRIES];
  logic ent_global [ENTRIES];
  // frame, coherency, dirty, valid of even and odd halves
  logic [28:0] ent_even [ENTRIES];
  logic [28:0] ent_odd [ENTRIES];

  // ----------------------------------------------------------------
  // staging registers
  // ----------------------------------------------------------------
  logic [1:0] hi_region_q, hi_region_d;
  logic [26:0] hi_paired_page_number_q, hi_paired_page_number_d;
  logic [7:0] hi_asid_q, hi_asid_d;
  logic [11:0] mask_q, mask_d;
  logic [29:0] lo_even_q, lo_even_d, lo_odd_q, lo_odd_d;
  logic [IW-1:0] index_q, index_d;
  logic probe_fail_q, probe_fail_d;
  logic [IW-1:0] random_q, random_d, wired_q, wired_d;
  logic [63:0] rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // match logic, a lookup and a probe comparator per entry
  // ----------------------------------------------------------------
  logic [ENTRIES-1:0] lk_hit, pr_hit;
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_cmp
      logic [26:0] cmp_mask;
      logic asid_ok;
      // masked low page bits take no part
      assign cmp_mask = {15'h7fff, ~ent_mask[gi]};
      assign asid_ok = ent_global[gi] || (ent_asid[gi] == hi_asid_q);
      // valid bit is absent from the comparison
      assign lk_hit[gi] = asid_ok &&
        (((lk_vaddr_in[`JPTB_HI_PAIRED_PAGE_NUMBER_HI:`JPTB_HI_PAIRED_PAGE_NUMBER_LO] ^ ent_paired_page_number[gi])
          & cmp_mask) == 27'h0);
      assign pr_hit[gi] = asid_ok &&
        (((hi_paired_page_number_q ^ ent_paired_page_number[gi]) & cmp_mask) == 27'h0);
    end
  endgenerate
  // lowest matching index wins; overlapping entries are a software fault
  logic lk_any, pr_any;
  logic [IW-1:0] lk_idx, pr_idx;
  always_comb begin
    lk_any = 1'b0;
    lk_idx = '0;
    pr_any = 1'b0;
    pr_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (lk_hit[i]) begin
        lk_any = 1'b1;
        lk_idx = IW'(i);
      end
      if (pr_hit[i]) begin
        pr_any = 1'b1;
        pr_idx = IW'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // even/odd half selection and lookup result
  // ----------------------------------------------------------------
  logic [12:0] ones, sel_bit;
  logic odd_half;
  logic [28:0] half;
  always_comb begin
    ones = {ent_mask[lk_idx], 1'b1};
    // topmost set bit of the mask run picks the pair bit
    sel_bit = ones & ~{1'b0, ones[12:1]};
    odd_half = |(sel_bit & lk_vaddr_in[24:`JPTB_PAGE_LSB]);
    half = odd_half ? ent_odd[lk_idx] : ent_even[lk_idx];
  end
  logic [23:0] frame_q, frame_d;
  logic [2:0] coh_q, coh_d;
  logic done_q, done_d, wr_ok_q, wr_ok_d, pvalid_q, pvalid_d;
  logic miss_q, miss_d, ld_fault_q, ld_fault_d, st_fault_q, st_fault_d;
  logic mod_q, mod_d;
  always_comb begin
    done_d = lk_valid_in;
    frame_d = frame_q;
    coh_d = coh_q;
    wr_ok_d = wr_ok_q;
    pvalid_d = pvalid_q;
    miss_d = 1'b0;
    ld_fault_d = 1'b0;
    st_fault_d = 1'b0;
    mod_d = 1'b0;
    if (lk_valid_in) begin
      // frame and access bits of the chosen half
      frame_d = half[28:5];
      coh_d = half[4:2];
      wr_ok_d = half[1];
      pvalid_d = half[0];
      if (!lk_any) begin
        miss_d = 1'b1;
        ld_fault_d = !lk_store_in;
        st_fault_d = lk_store_in;
        wr_ok_d = 1'b0;
        pvalid_d = 1'b0;
      end else if (!half[0]) begin
        ld_fault_d = !lk_store_in;
        st_fault_d = lk_store_in;
      end else if (lk_store_in && !half[1]) begin
        mod_d = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      frame_q <= 24'h0;
      coh_q <= 3'h0;
      wr_ok_q <= 1'b0;
      pvalid_q <= 1'b0;
      miss_q <= 1'b0;
      ld_fault_q <= 1'b0;
      st_fault_q <= 1'b0;
      mod_q <= 1'b0;
    end else begin
      done_q <= done_d;
      frame_q <= frame_d;
      coh_q <= coh_d;
      wr_ok_q <= wr_ok_d;
      pvalid_q <= pvalid_d;
      miss_q <= miss_d;
      ld_fault_q <= ld_fault_d;
      st_fault_q <= st_fault_d;
      mod_q <= mod_d;
    end
  end
  assign lk_done_out = done_q;
  assign lk_frame_number_out = frame_q;
  assign lk_coherency_out = coh_q;
  assign lk_writable_out = wr_ok_q;
  assign lk_page_valid_out = pvalid_q;
  assign lk_cacheable_out = (coh_q == `JPTB_COH_WRITEBACK);
  assign lk_coh_reserved_out = (coh_q != `JPTB_COH_UNCACHED) &&
    (coh_q != `JPTB_COH_WRITEBACK) && (coh_q != `JPTB_COH_UNC_ACCEL);
  assign lk_bypass_cache_out = (coh_q == `JPTB_COH_UNCACHED);
  assign lk_miss_out = miss_q;
  // only a miss selects the refill vector
  assign lk_refill_vector_out = miss_q;
  assign load_translation_fault_out = ld_fault_q;
  assign store_translation_fault_out = st_fault_q;
  assign lk_modify_fault_out = mod_q;
  // ----------------------------------------------------------------
  // maintenance operations and staging register writes
  // ----------------------------------------------------------------
  logic do_write;
  logic [IW-1:0] wr_idx;
  // indexed and random writes share one write path
  assign do_write = op_valid_in && (op_code_in == JPTB_OP_WRITE_INDEX ||
    op_code_in == JPTB_OP_WRITE_RANDOM);
  assign wr_idx = (op_code_in == JPTB_OP_WRITE_RANDOM) ? random_q : index_q;
  always_comb begin
    hi_region_d = hi_region_q;
    hi_paired_page_number_d = hi_paired_page_number_q;
    hi_asid_d = hi_asid_q;
    mask_d = mask_q;
    lo_even_d = lo_even_q;
    lo_odd_d = lo_odd_q;
    index_d = index_q;
    probe_fail_d = probe_fail_q;
    wired_d = wired_q;
    // count down from the top entry, wrapping at the wired count
    random_d = (random_q <= wired_q) ? TOP_INDEX : random_q - IW'(1);
    if (reg_wr_en_in) begin
      // reserved fields are simply never stored
      case (reg_num_in)
        `JPTB_REG_INDEX: index_d = reg_wdata_in[IW-1:0];
        `JPTB_REG_LO_EVEN: lo_even_d = reg_wdata_in[29:0];
        `JPTB_REG_LO_ODD: lo_odd_d = reg_wdata_in[29:0];
        `JPTB_REG_PAGE_MASK:
          mask_d = reg_wdata_in[`JPTB_MASK_HI:`JPTB_MASK_LO];
        `JPTB_REG_WIRED: begin
          wired_d = reg_wdata_in[IW-1:0];
          random_d = TOP_INDEX;
        end
        `JPTB_REG_ENTRY_HIGH: begin
          // fill bits are dropped, region kept
          hi_region_d = reg_wdata_in[`JPTB_HI_REGION_HI:`JPTB_HI_REGION_LO];
          hi_paired_page_number_d = reg_wdata_in[`JPTB_HI_PAIRED_PAGE_NUMBER_HI:`JPTB_HI_PAIRED_PAGE_NUMBER_LO];
          hi_asid_d = reg_wdata_in[`JPTB_HI_ASID_HI:`JPTB_HI_ASID_LO];
        end
        default: ;
      endcase
    end
    // a read or a probe hit in the same cycle overrides a register write
    if (op_valid_in) begin
      case (op_code_in)
        JPTB_OP_PROBE: begin
          // index on hit, failure bit on miss
          probe_fail_d = !pr_any;
          if (pr_any) begin
            index_d = pr_idx;
          end
        end
        JPTB_OP_READ: begin
          hi_region_d = ent_region[index_q];
          hi_paired_page_number_d = ent_paired_page_number[index_q];
          hi_asid_d = ent_asid[index_q];
          mask_d = ent_mask[index_q];
          lo_even_d = {ent_even[index_q], ent_global[index_q]};
          lo_odd_d = {ent_odd[index_q], ent_global[index_q]};
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hi_region_q <= 2'h0;
      hi_paired_page_number_q <= 27'h0;
      hi_asid_q <= 8'h0;
      mask_q <= 12'h0;
      lo_even_q <= 30'h0;
      lo_odd_q <= 30'h0;
      index_q <= '0;
      probe_fail_q <= 1'b0;
      random_q <= TOP_INDEX;
      wired_q <= IW'(`JPTB_WIRED_RESET);
    end else begin
      hi_region_q <= hi_region_d;
      hi_paired_page_number_q <= hi_paired_page_number_d;
      hi_asid_q <= hi_asid_d;
      mask_q <= mask_d;
      lo_even_q <= lo_even_d;
      lo_odd_q <= lo_odd_d;
      index_q <= index_d;
      probe_fail_q <= probe_fail_d;
      random_q <= random_d;
      wired_q <= wired_d;
    end
  end
  // entries hold no reset; software must fill them before mapping
  // every entry reachable by index
  always_ff @(posedge clk_in) begin
    if (do_write) begin
      ent_region[wr_idx] <= hi_region_q;
      ent_paired_page_number[wr_idx] <= hi_paired_page_number_q;
      ent_asid[wr_idx] <= hi_asid_q;
      ent_mask[wr_idx] <= mask_q;
      // global only when both halves say so
      ent_global[wr_idx] <= lo_even_q[`JPTB_LO_GLOBAL] &
        lo_odd_q[`JPTB_LO_GLOBAL];
      ent_even[wr_idx] <= lo_even_q[29:1];
      ent_odd[wr_idx] <= lo_odd_q[29:1];
    end
  end
  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 64'h0;
    case (reg_num_in)
      `JPTB_REG_INDEX: begin
        rdata_d[IW-1:0] = index_q;
        rdata_d[`JPTB_INDEX_FAIL] = probe_fail_q;
      end
      `JPTB_REG_RANDOM: rdata_d[IW-1:0] = random_q;
      `JPTB_REG_LO_EVEN: rdata_d[29:0] = lo_even_q;
      `JPTB_REG_LO_ODD: rdata_d[29:0] = lo_odd_q;
      `JPTB_REG_PAGE_MASK: rdata_d[`JPTB_MASK_HI:`JPTB_MASK_LO] = mask_q;
      `JPTB_REG_WIRED: rdata_d[IW-1:0] = wired_q;
      `JPTB_REG_ENTRY_HIGH: begin
        // no global position here; it reads as zero
        rdata_d[`JPTB_HI_REGION_HI:`JPTB_HI_REGION_LO] = hi_region_q;
        rdata_d[`JPTB_HI_PAIRED_PAGE_NUMBER_HI:`JPTB_HI_PAIRED_PAGE_NUMBER_LO] = hi_paired_page_number_q;
        rdata_d[`JPTB_HI_ASID_HI:`JPTB_HI_ASID_LO] = hi_asid_q;
      end
      default: rdata_d = 64'h0;
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 64'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata_out = rdata_q;

endmodule
